// ===== core/xbd_pkg.sv
// Package of constants for the X-Bus decode support block
package xbd_pkg;
	// Register port map, byte addresses on the local port
	localparam logic [7:0]  ADDR_COPROC_ERR     = 8'hF0; // Coprocessor error port
	localparam logic [7:0]  ADDR_PROG_RANGE     = 8'h40; // Programmable select range base
	localparam logic [7:0]  ADDR_PROG_MASK      = 8'h44; // Programmable select range mask
	localparam logic [7:0]  ADDR_XBUS_ENABLE    = 8'h48; // Chip select enable register
	localparam logic [7:0]  ADDR_XBUS_CONFIG    = 8'h4C; // Chip select config register
	localparam logic [7:0]  ADDR_IOAPIC_BASE    = 8'h50; // IOAPIC memory base
	localparam logic [7:0]  ADDR_STATUS         = 8'h54; // Status read-back

	// Enable register bit positions
	localparam int          EN_RTC_BIT          = 0;
	localparam int          EN_KBC_BIT          = 1;
	localparam int          EN_ROM_BIT          = 2;
	localparam int          EN_PROG_BIT         = 3;
	localparam int          EN_IOAPIC_BIT       = 4;
	// Config register bit positions
	localparam int          CFG_COPROC_BIT      = 0;

	// Reset values
	localparam logic [7:0]  RST_XBUS_ENABLE     = 8'h07;
	localparam logic [7:0]  RST_XBUS_CONFIG     = 8'h00;
	localparam logic [15:0] RST_PROG_RANGE      = 16'h0000;
	localparam logic [15:0] RST_PROG_MASK       = 16'h0003;
	localparam logic [31:0] RST_IOAPIC_BASE     = 32'hFEC0_0000;

	// Decode constants
	localparam logic [15:0] IO_KBC_DATA         = 16'h0060;
	localparam logic [15:0] IO_KBC_CMD          = 16'h0064;
	localparam logic [15:0] IO_RTC_ADDR         = 16'h0070;
	localparam logic [15:0] IO_RTC_DATA         = 16'h0071;
	localparam logic [15:0] IO_COPROC           = 16'h00F0;
	localparam logic [6:0]  ROM_LA_TOP          = 7'h7F;  // LA[23:17] all ones
	localparam logic [6:0]  ROM_LA_LOW          = 7'h07;  // LA[23:17] of E0000-FFFFF
	localparam logic [31:0] IOAPIC_SPAN_MASK    = 32'hFFFF_FFE0; // Two windows, 00h and 10h

	// Latch strobe length in ISA clock periods
	localparam logic [1:0]  ALE_SYSCLKS         = 2'h2;
	// Flush handshake timing, default flush time in PCI clocks
	localparam logic [3:0]  FLUSH_CYCLES        = 4'h4;

	// Handshake states
	typedef enum logic [3:0] {
		HS_IDLE  = 4'b0001,
		HS_FLUSH = 4'b0010,
		HS_ACK   = 4'b0100,
		HS_WAIT  = 4'b1000
	} xbd_hs_t;
endpackage

// ===== core/xbd_sync.sv
// Two-flop synchroniser, W bits in one instance
`timescale 1ns/1ps
module xbd_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_async,
	input  wire logic [W-1:0] i_rst_val,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta;

	// Each bit passes two flops; the first is read only by the second
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta[g]   <= 1'b1;
					o_sync[g] <= 1'b1;
				end else begin
					meta[g]   <= i_async[g];
					o_sync[g] <= meta[g];
				end
			end
		end
	endgenerate

	// Reset value input kept for future per-bit polarity; all pins idle high here
	logic unused_rst_val;
	assign unused_rst_val = ^i_rst_val;
endmodule

// ===== core/xbd_top.sv
// X-Bus peripheral decode, coprocessor error and IOAPIC handshake logic
//
// Behaviour
// - Programmable select on PCI-sourced subtractive ISA I/O in range
// - Programmable select also enables X-Bus buffer
// - ROM select decoded from SA/LA address
// - ROM select negated during DMA cycles
// - Keyboard select on I/O 60h and 64h
// - Keyboard select never during DMA
// - RTC select on I/O 71h accesses
// - RTC latch strobe on write to 70h
// - Strobe from write fall, two ISA clocks
// - Coprocessor error reporting only when enabled
// - Coprocessor error raises internal IRQ13 request
// - Write F0h with error asserts ignore-error
// - Ignore-error held until error input negates
// - No error at write: ignore-error stays negated
// - IOAPIC select: enabled, PCI cycle, in range
// - IOAPIC decode defaults FEC0_0000h and FEC0_0010h
// - Enable bit muxes request/ack onto shared pins
// - Acknowledge only after buffers fully flushed
// - Buffer enable only for enabled decoded peripherals
`timescale 1ns/1ps
module xbd_top
	import xbd_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	// Register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic [31:0] i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [31:0] o_reg_rdata,
	// ISA side
	input  wire logic [16:0] i_isa_sa,
	input  wire logic [6:0]  i_isa_la,
	input  wire logic        i_isa_ior_n,
	input  wire logic        i_isa_iow_n,
	input  wire logic        i_isa_memr_n,
	input  wire logic        i_isa_memw_n,
	input  wire logic        i_isa_dma_n,
	input  wire logic        i_isa_system_clock,
	input  wire logic        i_cyc_pci_master,
	input  wire logic        i_cyc_subtractive,
	// PCI memory decode for IOAPIC
	input  wire logic [31:0] i_pci_addr,
	input  wire logic        i_pci_mem_cycle,
	// Coprocessor and DMA flush
	input  wire logic        i_coproc_error_in_n,
	input  wire logic        i_flush_done,
	// Shared pins, then the select, strobe and handshake outputs
	input  wire logic        i_test_ioapic_request_n,
	input  wire logic        i_pci_bus_reset_req_n,
	output logic             o_prog_periph_select_n,
	output logic             o_firmware_rom_select_n,
	output logic             o_keyboard_ctrl_select_n,
	output logic             o_rtc_select_n,
	output logic             o_rtc_addr_latch_strobe,
	output logic             o_ignore_error_out_n,
	output logic             o_irq13,
	output logic             o_xbus_buffer_oe_n,
	output logic             o_ioapic_select_n,
	output logic             o_rst_ioapic_ack_n,
	output logic             o_test_mode_in_n,
	output logic             o_flush_req
);
	import xbd_pkg::*;

	// Reset release through two flops
	logic       rst_meta;
	logic       rst_n;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Pin synchronisers: commands, ISA clock, error, request
	logic [7:0] pin_raw;
	logic [7:0] pin_rst;
	logic [7:0] pin_s;
	assign pin_raw = {i_pci_bus_reset_req_n, i_isa_dma_n, i_test_ioapic_request_n,
		i_coproc_error_in_n, i_isa_system_clock, i_isa_memw_n, i_isa_memr_n,
		i_isa_iow_n};
	assign pin_rst = 8'hFF;
	xbd_sync #(.W(8)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n),
		.i_async   (pin_raw),
		.i_rst_val (pin_rst),
		.o_sync    (pin_s)
	);
	wire iow_n_s    = pin_s[0];
	wire memr_n_s   = pin_s[1];
	wire memw_n_s   = pin_s[2];
	wire isa_system_clock_s   = pin_s[3];
	wire coproc_error_in_n_n_s   = pin_s[4];
	wire req_n_s    = pin_s[5];
	wire dma_n_s    = pin_s[6];
	wire pci_bus_reset_n_n_s = pin_s[7];
	logic ior_m;
	logic ior_n_s;

	// IOR synchronised separately to keep the bundle byte wide
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ior_m   <= 1'b1;
			ior_n_s <= 1'b1;
		end else begin
			ior_m   <= i_isa_ior_n;
			ior_n_s <= ior_m;
		end
	end

	// Software registers
	logic [15:0] prog_select_range_reg;
	logic [15:0] prog_select_mask;
	logic [7:0]  xbus_cs_enable_reg;
	logic [7:0]  xbus_cs_config_reg;
	logic [31:0] ioapic_base;
	wire wr_range  = i_reg_wr && (i_reg_addr == ADDR_PROG_RANGE);
	wire wr_mask   = i_reg_wr && (i_reg_addr == ADDR_PROG_MASK);
	wire wr_enable = i_reg_wr && (i_reg_addr == ADDR_XBUS_ENABLE);
	wire wr_config = i_reg_wr && (i_reg_addr == ADDR_XBUS_CONFIG);
	wire wr_apic   = i_reg_wr && (i_reg_addr == ADDR_IOAPIC_BASE);
	wire wr_coproc = i_reg_wr && (i_reg_addr == ADDR_COPROC_ERR);

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prog_select_range_reg <= RST_PROG_RANGE;
			prog_select_mask      <= RST_PROG_MASK;
			xbus_cs_enable_reg    <= RST_XBUS_ENABLE;
			xbus_cs_config_reg    <= RST_XBUS_CONFIG;
			ioapic_base           <= RST_IOAPIC_BASE;
		end else begin
			if (wr_range)  prog_select_range_reg <= i_reg_wdata[15:0];
			if (wr_mask)   prog_select_mask      <= i_reg_wdata[15:0];
			if (wr_enable) xbus_cs_enable_reg    <= i_reg_wdata[7:0];
			if (wr_config) xbus_cs_config_reg    <= i_reg_wdata[7:0];
			if (wr_apic)   ioapic_base           <= i_reg_wdata & IOAPIC_SPAN_MASK;
		end
	end

	wire en_rtc    = xbus_cs_enable_reg[EN_RTC_BIT];
	wire en_kbc    = xbus_cs_enable_reg[EN_KBC_BIT];
	wire en_rom    = xbus_cs_enable_reg[EN_ROM_BIT];
	wire en_prog   = xbus_cs_enable_reg[EN_PROG_BIT];
	wire en_ioapic = xbus_cs_enable_reg[EN_IOAPIC_BIT];
	wire en_coproc = xbus_cs_config_reg[CFG_COPROC_BIT];

	// Address decodes; commands use synchronised levels
	wire [15:0] io_addr  = i_isa_sa[15:0];
	wire        io_cmd   = !ior_n_s || !iow_n_s;
	wire        mem_cmd  = !memr_n_s || !memw_n_s;
	wire        no_dma   = dma_n_s;
	wire        prog_hit = ((io_addr & ~prog_select_mask) ==
		(prog_select_range_reg & ~prog_select_mask));
	wire dec_prog = en_prog && io_cmd && i_cyc_pci_master && i_cyc_subtractive
		&& prog_hit;
	wire rom_la   = (i_isa_la == ROM_LA_TOP) ||
		((i_isa_la == ROM_LA_LOW) && i_isa_sa[16]);
	wire dec_rom  = en_rom && mem_cmd && rom_la && no_dma;
	wire dec_kbc  = en_kbc && io_cmd && no_dma &&
		((io_addr == IO_KBC_DATA) || (io_addr == IO_KBC_CMD));
	wire dec_rtc  = en_rtc && io_cmd && no_dma && (io_addr == IO_RTC_DATA);
	wire apic_hit = ((i_pci_addr & IOAPIC_SPAN_MASK) == ioapic_base);
	wire dec_apic = en_ioapic && i_pci_mem_cycle && i_cyc_pci_master && apic_hit;
	// Buffer only for enabled X-Bus peripherals; the program select rides on it
	wire dec_xoe  = dec_prog || dec_rom || dec_kbc || dec_rtc;

	// Latch strobe: IOW falling edge to port 70h, counted in ISA clocks
	logic       iow_d;
	logic       isa_system_clock_d;
	logic [1:0] ale_cnt;
	logic       ale_on;
	wire iow_fall   = iow_d && !iow_n_s;
	wire sys_rise   = !isa_system_clock_d && isa_system_clock_s;
	wire ale_start  = iow_fall && en_rtc && no_dma && (io_addr == IO_RTC_ADDR);
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			iow_d    <= 1'b1;
			isa_system_clock_d <= 1'b0;
			ale_cnt  <= 2'h0;
			ale_on   <= 1'b0;
		end else begin
			iow_d    <= iow_n_s;
			isa_system_clock_d <= isa_system_clock_s;
			if (ale_start) begin
				ale_on  <= 1'b1;
				ale_cnt <= 2'h0;
			end else if (ale_on && sys_rise) begin
				if (ale_cnt == ALE_SYSCLKS - 2'h1) begin
					ale_on <= 1'b0;
				end
				ale_cnt <= ale_cnt + 2'h1;
			end
		end
	end

	// Ignore-error: set on port write with error active, held until error clears
	logic ignore_error_out_n;
	wire  coproc_error_in_n_act = !coproc_error_in_n_n_s && en_coproc;
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ignore_error_out_n <= 1'b0;
		end else if (!coproc_error_in_n_act) begin
			ignore_error_out_n <= 1'b0;
		end else if (wr_coproc) begin
			ignore_error_out_n <= 1'b1;
		end
	end

	// Flush handshake; PCI reset forces idle so the ack stays negated
	xbd_hs_t    hs;
	xbd_hs_t    next_hs;
	logic [3:0] flush_cnt;
	wire        req_act = !req_n_s && en_ioapic;
	always_comb begin
		next_hs = hs;
		case (hs)
			HS_IDLE:  if (req_act) next_hs = HS_FLUSH;
			HS_FLUSH: if (!req_act) next_hs = HS_IDLE;
				else if (i_flush_done && flush_cnt == 4'h0) next_hs = HS_ACK;
			HS_ACK:   next_hs = HS_WAIT;
			HS_WAIT:  if (!req_act) next_hs = HS_IDLE;
			default:  next_hs = HS_IDLE;
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hs        <= HS_IDLE;
			flush_cnt <= FLUSH_CYCLES;
		end else if (!pci_bus_reset_n_n_s) begin
			hs        <= HS_IDLE;
			flush_cnt <= FLUSH_CYCLES;
		end else begin
			hs        <= next_hs;
			flush_cnt <= (hs == HS_FLUSH && flush_cnt != 4'h0) ? flush_cnt - 4'h1
				: (hs == HS_FLUSH ? flush_cnt : FLUSH_CYCLES);
		end
	end
	wire ack_on = (next_hs == HS_ACK || next_hs == HS_WAIT) && pci_bus_reset_n_n_s;

	// Registered outputs
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_prog_periph_select_n   <= 1'b1;
			o_firmware_rom_select_n  <= 1'b1;
			o_keyboard_ctrl_select_n <= 1'b1;
			o_rtc_select_n           <= 1'b1;
			o_rtc_addr_latch_strobe  <= 1'b0;
			o_ignore_error_out_n     <= 1'b1;
			o_irq13                  <= 1'b0;
			o_xbus_buffer_oe_n       <= 1'b1;
			o_ioapic_select_n        <= 1'b1;
			o_rst_ioapic_ack_n       <= 1'b0;
			o_test_mode_in_n         <= 1'b1;
			o_flush_req              <= 1'b0;
		end else begin
			o_prog_periph_select_n   <= !dec_prog;
			o_firmware_rom_select_n  <= !dec_rom;
			o_keyboard_ctrl_select_n <= !dec_kbc;
			o_rtc_select_n           <= !dec_rtc;
			o_rtc_addr_latch_strobe  <= ale_on;
			o_ignore_error_out_n     <= !ignore_error_out_n;
			o_irq13                  <= coproc_error_in_n_act;
			o_xbus_buffer_oe_n       <= !dec_xoe;
			o_ioapic_select_n        <= !dec_apic;
			// Shared pin: ack when enabled, else PCI reset pass-through
			o_rst_ioapic_ack_n       <= en_ioapic ? !ack_on : pci_bus_reset_n_n_s;
			o_test_mode_in_n         <= en_ioapic ? 1'b1 : req_n_s;
			// PCI reset holds the handshake idle, so no flush is asked for either
			o_flush_req              <= (next_hs == HS_FLUSH) && pci_bus_reset_n_n_s;
		end
	end

	// Read-back, one cycle after the strobe
	wire [31:0] status = {24'h0, 3'h0, hs == HS_WAIT, ale_on, !coproc_error_in_n_n_s, ignore_error_out_n, !req_n_s};
	logic [31:0] rd_mux;
	always_comb begin
		case (i_reg_addr)
			ADDR_PROG_RANGE:  rd_mux = {16'h0, prog_select_range_reg};
			ADDR_PROG_MASK:   rd_mux = {16'h0, prog_select_mask};
			ADDR_XBUS_ENABLE: rd_mux = {24'h0, xbus_cs_enable_reg};
			ADDR_XBUS_CONFIG: rd_mux = {24'h0, xbus_cs_config_reg};
			ADDR_IOAPIC_BASE: rd_mux = ioapic_base;
			ADDR_STATUS:      rd_mux = status;
			default:          rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) o_reg_rdata <= 32'h0;
		else        o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0;
	end
endmodule

// ===== tb/xbd_top_asserts.sv
// Port-level checks for the X-Bus decode support block
`timescale 1ns/1ps
module xbd_top_asserts (
	input wire logic        i_clk_sys,
	input wire logic        i_rst_n,
	input wire logic [16:0] i_isa_sa,
	input wire logic        i_isa_iow_n,
	input wire logic        i_isa_dma_n,
	input wire logic        i_cyc_pci_master,
	input wire logic        i_cyc_subtractive,
	input wire logic        i_coproc_error_in_n,
	input wire logic        i_test_ioapic_request_n,
	input wire logic        i_pci_bus_reset_req_n,
	input wire logic        o_prog_periph_select_n,
	input wire logic        o_firmware_rom_select_n,
	input wire logic        o_keyboard_ctrl_select_n,
	input wire logic        o_rtc_addr_latch_strobe,
	input wire logic        o_ignore_error_out_n,
	input wire logic        o_xbus_buffer_oe_n,
	input wire logic        o_rst_ioapic_ack_n
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// Five cycles of DMA cover the synchronisers and the output flop
	chk_kbc_no_dma: assert property (
		(!i_isa_dma_n)[*5] |-> o_keyboard_ctrl_select_n) else $error("kbc select in DMA");
	chk_rom_no_dma: assert property (
		(!i_isa_dma_n)[*5] |-> o_firmware_rom_select_n) else $error("rom select in DMA");
	// Same-clock qualifiers lead the select by one cycle
	chk_prog_source: assert property (
		!o_prog_periph_select_n |-> $past(i_cyc_pci_master) && $past(i_cyc_subtractive))
		else $error("prog select without PCI subtractive cycle");
	chk_prog_buffer: assert property (
		!o_prog_periph_select_n |-> !o_xbus_buffer_oe_n) else $error("prog select, buffer off");
	// Strobe stays high at least seven cycles but does not hang
	chk_strobe_len: assert property (
		$rose(o_rtc_addr_latch_strobe) |-> o_rtc_addr_latch_strobe[*7] ##[1:12]
		!o_rtc_addr_latch_strobe) else $error("latch strobe length wrong");
	chk_strobe_cause: assert property (
		$rose(o_rtc_addr_latch_strobe) |-> !$past(i_isa_iow_n, 3) && $past(i_isa_sa, 3) == 17'h00070)
		else $error("latch strobe without write to 70h");
	chk_ignore_free: assert property (
		i_coproc_error_in_n[*5] |-> o_ignore_error_out_n) else $error("ignore without error");
	chk_ack_release: assert property (
		(i_test_ioapic_request_n && i_pci_bus_reset_req_n)[*6] |-> o_rst_ioapic_ack_n)
		else $error("ack held without request");
	cov_strobe: cover property ($rose(o_rtc_addr_latch_strobe));
	cov_ignore: cover property ($fell(o_ignore_error_out_n));
	cov_ack: cover property ($fell(o_rst_ioapic_ack_n) && i_pci_bus_reset_req_n);
endmodule
bind xbd_top xbd_top_asserts xbd_top_asserts_i (.*);

// ===== tb/xbd_ioapic_model.sv
// Behavioural external interrupt unit: request, wait for acknowledge, send, release
`timescale 1ns/1ps
module xbd_ioapic_model #(
	parameter int SEND = 6
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rst_n,
	input  wire logic i_go,
	input  wire logic i_slow,
	input  wire logic i_ack_n,
	output logic      o_req_n,
	output logic      o_acked
);
	int n = 0;
	initial o_req_n = 1'b1;
	initial o_acked = 1'b0;
	// Moves only on rising clock edges or at reset, as a clocked part would
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_req_n <= 1'b1;
			o_acked <= 1'b0;
			n <= 0;
		end else if (n == 0 && i_go) begin
			o_req_n <= 1'b0; // Request goes out before any message
			o_acked <= 1'b0;
			n <= 1;
		end else if (n == 40 || n == 100 + (i_slow ? 4 * SEND : SEND)) begin
			o_req_n <= 1'b1; // Message sent, or the wait was abandoned
			n <= 0;
		end else if (n > 0) begin
			// Nothing is sent until the acknowledge is seen
			if (n < 100 && !i_ack_n)
				o_acked <= 1'b1;
			n <= (n < 100 && !i_ack_n) ? 100 : n + 1;
		end
	end
endmodule

// ===== tb/xbus_decode_support_tb_top.sv
// Self-checking bench for the X-Bus decode support block
`timescale 1ns/1ps
module xbus_decode_support_tb_top;
	import xbd_pkg::*;
	logic        i_clk_sys = 1'b0, i_rst_n = 1'b0, i_isa_system_clock = 1'b0;
	logic [7:0]  i_reg_addr = 8'h00;
	logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, i_pci_addr = 32'h0, rdv;
	logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic [16:0] i_isa_sa = 17'h0;
	logic [6:0]  i_isa_la = 7'h0;
	logic        i_isa_ior_n = 1'b1, i_isa_iow_n = 1'b1, i_isa_memr_n = 1'b1, i_isa_memw_n = 1'b1;
	logic        i_isa_dma_n = 1'b1, i_cyc_pci_master = 1'b0, i_cyc_subtractive = 1'b0;
	logic        i_pci_mem_cycle = 1'b0, i_coproc_error_in_n = 1'b1, i_flush_done = 1'b0;
	logic        i_test_ioapic_request_n, i_pci_bus_reset_req_n = 1'b1, go = 1'b0, slow = 1'b1;
	logic        o_prog_periph_select_n, o_firmware_rom_select_n, o_keyboard_ctrl_select_n;
	logic        o_rtc_select_n, o_rtc_addr_latch_strobe, o_ignore_error_out_n, o_irq13;
	logic        o_xbus_buffer_oe_n, o_ioapic_select_n, o_rst_ioapic_ack_n, o_test_mode_in_n;
	logic        o_flush_req, acked;
	int          mismatches = 0, num_checks = 0, k, n;
	// ISA clock is unrelated in phase to the system clock, 8.26 system cycles a period
	always #50 i_clk_sys = ~i_clk_sys;
	always #413 i_isa_system_clock = ~i_isa_system_clock;
	xbd_top xbd_top_i (.*);
	xbd_ioapic_model #(.SEND(6)) xbd_ioapic_model_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_go(go), .i_slow(slow), .i_ack_n(o_rst_ioapic_ack_n),
		.o_req_n(i_test_ioapic_request_n), .o_acked(acked));
	task cyc(input int c);
		repeat (c) @(posedge i_clk_sys);
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// One-cycle strobes with a gap, so no signal is assigned twice in a step
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		cyc(1);
		i_reg_wr <= 1'b0;
		cyc(1);
	endtask
	task rd(input logic [7:0] a);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		cyc(1);
		i_reg_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe; take them once settled
		#1;
		rdv = o_reg_rdata;
		cyc(1);
	endtask
	task t_regs;
		rd(ADDR_XBUS_ENABLE);
		check(rdv, 32'h00000007, "enable reset value");
		rd(ADDR_IOAPIC_BASE);
		check(rdv, 32'hFEC00000, "ioapic base default");
		wr(ADDR_XBUS_ENABLE, 32'h0000001F);
		rd(ADDR_XBUS_ENABLE);
		check(rdv, 32'h0000001F, "enable write");
		rd(8'h10);
		check(rdv, 32'h0, "unmapped read");
		rd(ADDR_COPROC_ERR);
		check(rdv, 32'h0, "write-only read");
		$display("test regs done");
	endtask
	task t_kbc;
		logic [16:0] a [3] = '{17'h00060, 17'h00064, 17'h00062};
		for (int j = 0; j < 3; j++) begin
			i_isa_sa <= a[j];
			i_isa_ior_n <= 1'b0;
			cyc(5);
			check(o_keyboard_ctrl_select_n, j == 2, "kbc decode");
			i_isa_dma_n <= 1'b0;
			cyc(5);
			check(o_keyboard_ctrl_select_n, 1, "kbc in DMA");
			i_isa_dma_n <= 1'b1;
			i_isa_ior_n <= 1'b1;
			cyc(4);
		end
		$display("test kbc done");
	endtask
	task t_rtc;
		i_isa_sa <= 17'h00071;
		i_isa_ior_n <= 1'b0;
		cyc(5);
		check(o_rtc_select_n, 0, "rtc select");
		i_isa_ior_n <= 1'b1;
		i_isa_sa <= 17'h00070;
		cyc(4);
		i_isa_iow_n <= 1'b0;
		for (k = 0; k < 10 && !o_rtc_addr_latch_strobe; k++) cyc(1);
		for (n = 0; n < 30 && o_rtc_addr_latch_strobe; n++) cyc(1);
		check(k < 10 && n >= 8 && n <= 17, 1, "latch strobe");
		if (k == 10 || n == 30) report_and_stop;
		i_isa_iow_n <= 1'b1;
		cyc(4);
		$display("test rtc done");
	endtask
	task t_rom;
		i_isa_la <= 7'h7F;
		i_isa_sa <= 17'h1FFF0;
		i_isa_memr_n <= 1'b0;
		cyc(5);
		check(o_firmware_rom_select_n, 0, "rom select");
		i_isa_dma_n <= 1'b0;
		cyc(5);
		check(o_firmware_rom_select_n, 1, "rom in DMA");
		i_isa_dma_n <= 1'b1;
		i_isa_memr_n <= 1'b1;
		i_isa_la <= 7'h00;
		cyc(4);
		$display("test rom done");
	endtask
	task t_prog;
		wr(ADDR_PROG_RANGE, 32'h00000300);
		i_cyc_pci_master <= 1'b1;
		i_cyc_subtractive <= 1'b1;
		i_isa_sa <= 17'h00302;
		i_isa_iow_n <= 1'b0;
		cyc(5);
		check(o_prog_periph_select_n, 0, "prog select");
		check(o_xbus_buffer_oe_n, 0, "prog buffer");
		i_cyc_subtractive <= 1'b0;
		cyc(3);
		check(o_prog_periph_select_n, 1, "prog positive");
		i_isa_iow_n <= 1'b1;
		i_cyc_pci_master <= 1'b0;
		cyc(4);
		$display("test prog done");
	endtask
	task t_coproc;
		wr(ADDR_XBUS_CONFIG, 32'h00000001);
		i_coproc_error_in_n <= 1'b0;
		cyc(5);
		check(o_irq13, 1, "irq13");
		wr(ADDR_COPROC_ERR, 32'h0);
		cyc(3);
		check(o_ignore_error_out_n, 0, "ignore set");
		cyc(8);
		check(o_ignore_error_out_n, 0, "ignore held");
		i_coproc_error_in_n <= 1'b1;
		cyc(5);
		wr(ADDR_COPROC_ERR, 32'h0);
		cyc(3);
		check(o_ignore_error_out_n, 1, "no error");
		wr(ADDR_XBUS_CONFIG, 32'h0);
		i_coproc_error_in_n <= 1'b0;
		cyc(4);
		wr(ADDR_COPROC_ERR, 32'h0);
		cyc(3);
		check(o_ignore_error_out_n, 1, "reporting off");
		check(o_irq13, 0, "irq13 off");
		i_coproc_error_in_n <= 1'b1;
		cyc(5);
		$display("test coproc done");
	endtask
	task t_ioapic;
		i_pci_addr <= 32'hFEC0_0010;
		i_pci_mem_cycle <= 1'b1;
		i_cyc_pci_master <= 1'b1;
		cyc(3);
		check(o_ioapic_select_n, 0, "ioapic select");
		i_pci_addr <= 32'hFEC0_0000;
		cyc(3);
		check(o_ioapic_select_n, 0, "ioapic select base");
		i_pci_addr <= 32'hFEC0_0020;
		cyc(3);
		check(o_ioapic_select_n, 1, "ioapic miss");
		i_pci_mem_cycle <= 1'b0;
		i_cyc_pci_master <= 1'b0;
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(10);
		check(o_flush_req, 1, "flush");
		check(o_rst_ioapic_ack_n, 1, "early ack");
		i_flush_done <= 1'b1;
		for (k = 0; k < 20 && !acked; k++) cyc(1);
		check(acked, 1, "ack");
		if (!acked) report_and_stop;
		cyc(35);
		check(o_rst_ioapic_ack_n, 1, "ack release");
		i_pci_bus_reset_req_n <= 1'b0;
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(12);
		check(o_rst_ioapic_ack_n, 1, "ack in reset");
		check(o_flush_req, 0, "flush in reset");
		cyc(32);
		i_pci_bus_reset_req_n <= 1'b1;
		wr(ADDR_XBUS_ENABLE, 32'h0000000F);
		go <= 1'b1;
		cyc(1);
		go <= 1'b0;
		cyc(5);
		check(o_test_mode_in_n, 0, "test pin");
		check(o_rst_ioapic_ack_n, 1, "reset pin");
		cyc(40);
		$display("test ioapic done");
	endtask
	initial begin
		repeat (2) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		cyc(4);
		t_regs;
		t_kbc;
		t_rtc;
		t_rom;
		t_prog;
		t_coproc;
		t_ioapic;
		report_and_stop;
	end
endmodule
